// *** logic/pll_lock_status_readback.sv ***
// Top of the read-only loop status register bank with snapshot on update.
`timescale 1ns/10ps
module pll_lock_status_readback
	import pll_status_pkg::*;
(
	input  wire logic                                 ref_clk_i,
	input  wire logic                                 rst_i,
	input  wire logic                                 ce_i,
	input  wire logic [pll_status_pkg::ADDR_W-1:0]    addr_i,
	input  wire logic [pll_status_pkg::DATA_W-1:0]    wdata_i,
	input  wire logic                                 wr_i,
	input  wire logic                                 rd_i,
	output logic      [pll_status_pkg::DATA_W-1:0]    rdata_o,
	output logic                                      update_o,
	input  wire logic [pll_status_pkg::BUCKET_W-1:0]  l0_phase_bucket_i,
	input  wire logic [pll_status_pkg::BUCKET_W-1:0]  l0_freq_bucket_i,
	input  wire logic [pll_status_pkg::BUCKET_W-1:0]  l1_phase_bucket_i,
	input  wire logic [pll_status_pkg::BUCKET_W-1:0]  l1_freq_bucket_i,
	input  wire logic [pll_status_pkg::TWORD_W-1:0]   l1_tword_i,
	input  wire logic                                 sysclk_locked_i,
	input  wire logic                                 analog_loop_one_cal_i,
	input  wire logic                                 analog_loop_one_locked_i,
	input  wire logic                                 digital_loop_one_freq_lock_i,
	input  wire logic                                 digital_loop_one_phase_lock_i,
	input  wire pll_status_pkg::ref_sel_t             digital_loop_one_ref_i,
	input  wire logic                                 digital_loop_one_switching_i,
	input  wire logic                                 digital_loop_one_holdover_i,
	input  wire logic                                 digital_loop_one_free_run_i,
	input  wire logic                                 digital_loop_one_slew_limited_i,
	input  wire logic                                 digital_loop_one_clamped_i,
	input  wire logic                                 digital_loop_one_history_i
);
	import pll_status_pkg::*;

	status_bus_if snap_bus ();

	logic [4:0]        ch1_live;
	logic [4:0]        state_live;
	logic [2:0]        flags_live;
	logic              update_hit;
	logic [DATA_W-1:0] mux_data;
	logic              mux_hit;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              update_r;
	logic              all_locked;

	assign all_locked = sysclk_locked_i & analog_loop_one_locked_i
		& digital_loop_one_freq_lock_i & digital_loop_one_phase_lock_i;

	always_comb begin
		ch1_live = '0;
		ch1_live[CAL_BIT]   = analog_loop_one_cal_i;
		ch1_live[ALOCK_BIT] = analog_loop_one_locked_i;
		ch1_live[FLOCK_BIT] = digital_loop_one_freq_lock_i;
		ch1_live[PLOCK_BIT] = digital_loop_one_phase_lock_i;
		ch1_live[ALL_BIT]   = all_locked;
		state_live = '0;
		state_live[REF_LSB +: 2] = digital_loop_one_ref_i;
		state_live[SWITCH_BIT]   = digital_loop_one_switching_i;
		state_live[HOLD_BIT]     = digital_loop_one_holdover_i;
		state_live[FREE_BIT]     = digital_loop_one_free_run_i;
		flags_live = '0;
		flags_live[SLEW_BIT]  = digital_loop_one_slew_limited_i;
		flags_live[CLAMP_BIT] = digital_loop_one_clamped_i;
		flags_live[HIST_BIT]  = digital_loop_one_history_i;
	end

	// Only the update code at the update address moves the snapshot.
	assign update_hit = wr_i && (addr_i == UPDATE_ADDR) && (wdata_i == UPDATE_CODE);

	status_snapshot u_snapshot (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.take_i     (update_hit),
		.l0_phase_i (l0_phase_bucket_i),
		.l0_freq_i  (l0_freq_bucket_i),
		.l1_phase_i (l1_phase_bucket_i),
		.l1_freq_i  (l1_freq_bucket_i),
		.l1_tword_i (l1_tword_i),
		.ch1_lock_i (ch1_live),
		.l1_state_i (state_live),
		.l1_flags_i (flags_live),
		.snap       (snap_bus.producer)
	);

	status_read_mux u_mux (
		.addr_i (addr_i),
		.snap   (snap_bus.consumer),
		.data_o (mux_data),
		.hit_o  (mux_hit)
	);

	// Writes to status addresses have no path into any register.
	assign rdata_nxt = (rd_i && mux_hit) ? mux_data : ZERO_BYTE;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_r  <= ZERO_BYTE;
			update_r <= 1'b0;
		end else if (ce_i) begin
			rdata_r  <= rdata_nxt;
			update_r <= update_hit;
		end
	end

	assign rdata_o  = rdata_r;
	assign update_o = update_r;
endmodule : pll_lock_status_readback

// *** logic/pll_status_pkg.sv ***
// Package with register map, field positions and widths of the loop status bank.
package pll_status_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int BUCKET_W = 12;
	localparam int TWORD_W = 30;
	localparam logic [ADDR_W-1:0] UPDATE_ADDR = 16'h0005;
	localparam logic [DATA_W-1:0] UPDATE_CODE = 8'h01;
	localparam logic [ADDR_W-1:0] L0_PHASE_LO_ADDR = 16'h0d27;
	localparam logic [ADDR_W-1:0] L0_PHASE_HI_ADDR = 16'h0d28;
	localparam logic [ADDR_W-1:0] L0_FREQ_LO_ADDR = 16'h0d29;
	localparam logic [ADDR_W-1:0] L0_FREQ_HI_ADDR = 16'h0d2a;
	localparam logic [ADDR_W-1:0] CH1_LOCK_ADDR = 16'h0d40;
	localparam logic [ADDR_W-1:0] L1_STATE_ADDR = 16'h0d41;
	localparam logic [ADDR_W-1:0] L1_FLAGS_ADDR = 16'h0d42;
	localparam logic [ADDR_W-1:0] L1_TWORD0_ADDR = 16'h0d43;
	localparam logic [ADDR_W-1:0] L1_TWORD1_ADDR = 16'h0d44;
	localparam logic [ADDR_W-1:0] L1_TWORD2_ADDR = 16'h0d45;
	localparam logic [ADDR_W-1:0] L1_TWORD3_ADDR = 16'h0d46;
	localparam logic [ADDR_W-1:0] L1_PHASE_LO_ADDR = 16'h0d47;
	localparam logic [ADDR_W-1:0] L1_PHASE_HI_ADDR = 16'h0d48;
	localparam logic [ADDR_W-1:0] L1_FREQ_LO_ADDR = 16'h0d49;
	localparam logic [ADDR_W-1:0] L1_FREQ_HI_ADDR = 16'h0d4a;
	localparam int CAL_BIT = 4;
	localparam int ALOCK_BIT = 3;
	localparam int FLOCK_BIT = 2;
	localparam int PLOCK_BIT = 1;
	localparam int ALL_BIT = 0;
	localparam int REF_LSB = 3;
	localparam int SWITCH_BIT = 2;
	localparam int HOLD_BIT = 1;
	localparam int FREE_BIT = 0;
	localparam int SLEW_BIT = 2;
	localparam int CLAMP_BIT = 1;
	localparam int HIST_BIT = 0;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [BUCKET_W-1:0] BUCKET_RST = 12'h000;
	localparam logic [TWORD_W-1:0] TWORD_RST = 30'h00000000;
	typedef enum logic [1:0] {
		REF_A,
		REF_B,
		REF_C,
		REF_D
	} ref_sel_t;
endpackage : pll_status_pkg

// *** logic/status_bus_if.sv ***
// Interface carrying the snapshot of loop status from capture to read mux.
`timescale 1ns/10ps
interface status_bus_if;
	import pll_status_pkg::*;
	logic [BUCKET_W-1:0] l0_phase;
	logic [BUCKET_W-1:0] l0_freq;
	logic [BUCKET_W-1:0] l1_phase;
	logic [BUCKET_W-1:0] l1_freq;
	logic [TWORD_W-1:0]  l1_tword;
	logic [4:0]          ch1_lock;
	logic [4:0]          l1_state;
	logic [2:0]          l1_flags;
	modport producer (output l0_phase, l0_freq, l1_phase, l1_freq, l1_tword,
		ch1_lock, l1_state, l1_flags);
	modport consumer (input l0_phase, l0_freq, l1_phase, l1_freq, l1_tword,
		ch1_lock, l1_state, l1_flags);
endinterface : status_bus_if

// *** logic/status_read_mux.sv ***
// Read multiplexer that maps snapshot fields onto byte registers.
`timescale 1ns/10ps
module status_read_mux
	import pll_status_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr_i,
	status_bus_if.consumer         snap,
	output logic      [DATA_W-1:0] data_o,
	output logic                   hit_o
);
	function automatic logic [DATA_W-1:0] lo_byte(input logic [BUCKET_W-1:0] v);
		lo_byte = v[7:0];
	endfunction : lo_byte

	function automatic logic [DATA_W-1:0] hi_nib(input logic [BUCKET_W-1:0] v);
		hi_nib = {4'h0, v[BUCKET_W-1:8]};
	endfunction : hi_nib

	always_comb begin
		data_o = ZERO_BYTE;
		hit_o  = 1'b1;
		case (addr_i)
			L0_PHASE_LO_ADDR: data_o = lo_byte(snap.l0_phase);
			L0_PHASE_HI_ADDR: data_o = hi_nib(snap.l0_phase);
			L0_FREQ_LO_ADDR:  data_o = lo_byte(snap.l0_freq);
			L0_FREQ_HI_ADDR:  data_o = hi_nib(snap.l0_freq);
			CH1_LOCK_ADDR:    data_o = {3'h0, snap.ch1_lock};
			L1_STATE_ADDR:    data_o = {3'h0, snap.l1_state};
			L1_FLAGS_ADDR:    data_o = {5'h00, snap.l1_flags};
			L1_TWORD0_ADDR:   data_o = snap.l1_tword[7:0];
			L1_TWORD1_ADDR:   data_o = snap.l1_tword[15:8];
			L1_TWORD2_ADDR:   data_o = snap.l1_tword[23:16];
			L1_TWORD3_ADDR:   data_o = {2'h0, snap.l1_tword[29:24]};
			L1_PHASE_LO_ADDR: data_o = lo_byte(snap.l1_phase);
			L1_PHASE_HI_ADDR: data_o = hi_nib(snap.l1_phase);
			L1_FREQ_LO_ADDR:  data_o = lo_byte(snap.l1_freq);
			L1_FREQ_HI_ADDR:  data_o = hi_nib(snap.l1_freq);
			default:          hit_o = 1'b0;
		endcase
	end
endmodule : status_read_mux

// *** logic/status_snapshot.sv ***
// Snapshot registers that copy live loop status when software strobes an update.
`timescale 1ns/10ps
module status_snapshot
	import pll_status_pkg::*;
(
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                take_i,
	input  wire logic [BUCKET_W-1:0] l0_phase_i,
	input  wire logic [BUCKET_W-1:0] l0_freq_i,
	input  wire logic [BUCKET_W-1:0] l1_phase_i,
	input  wire logic [BUCKET_W-1:0] l1_freq_i,
	input  wire logic [TWORD_W-1:0]  l1_tword_i,
	input  wire logic [4:0]          ch1_lock_i,
	input  wire logic [4:0]          l1_state_i,
	input  wire logic [2:0]          l1_flags_i,
	status_bus_if.producer           snap
);
	logic [BUCKET_W-1:0] l0_phase_r;
	logic [BUCKET_W-1:0] l0_freq_r;
	logic [BUCKET_W-1:0] l1_phase_r;
	logic [BUCKET_W-1:0] l1_freq_r;
	logic [TWORD_W-1:0]  l1_tword_r;
	logic [4:0]          ch1_lock_r;
	logic [4:0]          l1_state_r;
	logic [2:0]          l1_flags_r;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			l0_phase_r <= BUCKET_RST;
			l0_freq_r  <= BUCKET_RST;
			l1_phase_r <= BUCKET_RST;
			l1_freq_r  <= BUCKET_RST;
			l1_tword_r <= TWORD_RST;
			ch1_lock_r <= '0;
			l1_state_r <= '0;
			l1_flags_r <= '0;
		end else if (ce_i && take_i) begin
			l0_phase_r <= l0_phase_i;
			l0_freq_r  <= l0_freq_i;
			l1_phase_r <= l1_phase_i;
			l1_freq_r  <= l1_freq_i;
			l1_tword_r <= l1_tword_i;
			ch1_lock_r <= ch1_lock_i;
			l1_state_r <= l1_state_i;
			l1_flags_r <= l1_flags_i;
		end
	end

	assign snap.l0_phase = l0_phase_r;
	assign snap.l0_freq  = l0_freq_r;
	assign snap.l1_phase = l1_phase_r;
	assign snap.l1_freq  = l1_freq_r;
	assign snap.l1_tword = l1_tword_r;
	assign snap.ch1_lock = ch1_lock_r;
	assign snap.l1_state = l1_state_r;
	assign snap.l1_flags = l1_flags_r;
endmodule : status_snapshot

// *** sim/pll_status_chk.sv ***
// Port checks for the loop status register bank.
`timescale 1ns/10ps
module pll_status_chk
	import pll_status_pkg::*;
(
	input wire logic              ref_clk_i,
	input wire logic              rst_i,
	input wire logic              ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic              update_o,
	input wire logic              analog_loop_one_cal_i,
	input wire logic              analog_loop_one_locked_i,
	input wire logic              digital_loop_one_freq_lock_i,
	input wire logic              digital_loop_one_phase_lock_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire rd_ok = rd_i && ce_i;
	wire up_ok = wr_i && ce_i && addr_i == UPDATE_ADDR && wdata_i == UPDATE_CODE;
	wire mapped = addr_i inside {[L0_PHASE_LO_ADDR:L0_FREQ_HI_ADDR],
		[CH1_LOCK_ADDR:L1_FREQ_HI_ADDR]};
	wire hi_byte = addr_i inside {L0_PHASE_HI_ADDR, L0_FREQ_HI_ADDR,
		L1_PHASE_HI_ADDR, L1_FREQ_HI_ADDR};
	wire [3:0] live = {analog_loop_one_cal_i, analog_loop_one_locked_i,
		digital_loop_one_freq_lock_i, digital_loop_one_phase_lock_i};
	sequence s_upd; up_ok; endsequence
	sequence s_rd_lock; rd_ok && addr_i == CH1_LOCK_ADDR; endsequence
	a_update_pulse: assert property (s_upd |=> update_o)
		else $error("update pulse missing");
	a_update_cause: assert property (update_o && $past(ce_i) |-> $past(up_ok))
		else $error("update pulse without update write");
	a_idle_zero: assert property (ce_i && !rd_i |=> rdata_o == ZERO_BYTE)
		else $error("read data not zero when idle");
	a_unmapped_zero: assert property (rd_ok && !mapped |=> rdata_o == ZERO_BYTE)
		else $error("unmapped read not zero");
	a_bucket_resv: assert property (rd_ok && hi_byte |=> rdata_o[7:4] == 4'h0)
		else $error("bucket high byte upper bits set");
	property p_lock_snap;
		s_upd ##1 s_rd_lock |=> rdata_o[4:1] == $past(live, 2);
	endproperty
	a_lock_snap: assert property (p_lock_snap)
		else $error("lock byte differs from captured inputs");
	a_all_lock: assert property (s_rd_lock |=> !rdata_o[0] || &rdata_o[3:1])
		else $error("all locked set with a loop unlocked");
	a_state_resv: assert property (rd_ok && addr_i == L1_STATE_ADDR |=> rdata_o[7:5] == 3'h0)
		else $error("state byte upper bits set");
	a_flag_resv: assert property (rd_ok && addr_i == L1_FLAGS_ADDR |=> rdata_o[7:3] == 5'h00)
		else $error("flag byte upper bits set");
	a_tword_resv: assert property (rd_ok && addr_i == L1_TWORD3_ADDR |=> rdata_o[7:6] == 2'h0)
		else $error("tuning word top byte upper bits set");
endmodule : pll_status_chk
bind pll_lock_status_readback pll_status_chk u_pll_status_chk (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .update_o(update_o), .analog_loop_one_cal_i(analog_loop_one_cal_i),
	.analog_loop_one_locked_i(analog_loop_one_locked_i),
	.digital_loop_one_freq_lock_i(digital_loop_one_freq_lock_i),
	.digital_loop_one_phase_lock_i(digital_loop_one_phase_lock_i));

// *** sim/tb_top.sv ***
// Self-checking bench for the loop status register bank.
`timescale 1ns/10ps
module tb_top;
	import pll_status_pkg::*;
	logic ref_clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, pend = 0, upd_d = 0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0, rdata_o, exp_v;
	logic update_o;
	logic [95:0] lv = '0, sv = '0, nv;
	logic [DATA_W-1:0] q[$];
	logic [15:0] al[19] = '{16'h0d27, 16'h0d28, 16'h0d29, 16'h0d2a, 16'h0d41, 16'h0d42,
		16'h0d43, 16'h0d44, 16'h0d45, 16'h0d46, 16'h0d47, 16'h0d48, 16'h0d49, 16'h0d4a,
		16'h0d2b, 16'h0005, 16'h0d3f, 16'h0d4b, 16'h0d40};
	int n_fail = 0, total_checks = 0, it = 0;
	integer seed = 32'hfa1363bb;
	always #2.5 ref_clk_i = ~ref_clk_i;
	pll_lock_status_readback u_pll_lock_status_readback (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .update_o(update_o), .l0_phase_bucket_i(lv[11:0]),
		.l0_freq_bucket_i(lv[23:12]), .l1_phase_bucket_i(lv[35:24]),
		.l1_freq_bucket_i(lv[47:36]), .l1_tword_i(lv[77:48]), .sysclk_locked_i(lv[78]),
		.analog_loop_one_cal_i(lv[79]), .analog_loop_one_locked_i(lv[80]),
		.digital_loop_one_freq_lock_i(lv[81]), .digital_loop_one_phase_lock_i(lv[82]),
		.digital_loop_one_ref_i(ref_sel_t'(lv[84:83])), .digital_loop_one_switching_i(lv[85]),
		.digital_loop_one_holdover_i(lv[86]), .digital_loop_one_free_run_i(lv[87]),
		.digital_loop_one_slew_limited_i(lv[88]), .digital_loop_one_clamped_i(lv[89]),
		.digital_loop_one_history_i(lv[90]));
	function automatic logic [7:0] exb(input logic [15:0] a);
		case (a)
			16'h0d27: return sv[7:0];
			16'h0d28: return {4'h0, sv[11:8]};
			16'h0d29: return sv[19:12];
			16'h0d2a: return {4'h0, sv[23:20]};
			16'h0d40: return {3'h0, sv[79], sv[80], sv[81], sv[82], &{sv[78], sv[82:80]}};
			16'h0d41: return {3'h0, sv[84:83], sv[85], sv[86], sv[87]};
			16'h0d42: return {5'h00, sv[88], sv[89], sv[90]};
			16'h0d43: return sv[55:48];
			16'h0d44: return sv[63:56];
			16'h0d45: return sv[71:64];
			16'h0d46: return {2'h0, sv[77:72]};
			16'h0d47: return sv[31:24];
			16'h0d48: return {4'h0, sv[35:32]};
			16'h0d49: return sv[43:36];
			16'h0d4a: return {4'h0, sv[47:44]};
			default: return 8'h00;
		endcase
	endfunction : exb
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(posedge ref_clk_i);
		nv = {$random(seed), $random(seed), $random(seed)};
		if (w && a == UPDATE_ADDR && d == UPDATE_CODE) begin
			nv[84:83] = it[1:0];
			if (it[2]) nv[82:78] = nv[82:78] | 5'h1d;
			sv = nv;
		end
		if (!w) q.push_back(exb(a));
		lv <= nv;
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
	endtask : acc
	task automatic idle();
		@(posedge ref_clk_i);
		wr_i <= 0;
		rd_i <= 0;
	endtask : idle
	// Two accesses with the clock enable low must leave every register untouched.
	task automatic frz();
		@(posedge ref_clk_i);
		ce_i <= 0;
		lv <= ~lv;
		addr_i <= UPDATE_ADDR;
		wdata_i <= UPDATE_CODE;
		wr_i <= 1;
		rd_i <= 0;
		@(posedge ref_clk_i);
		addr_i <= CH1_LOCK_ADDR;
		wr_i <= 0;
		rd_i <= 1;
		@(posedge ref_clk_i);
		ce_i <= 1;
		rd_i <= 0;
	endtask : frz
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d.", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	always @(posedge ref_clk_i) begin
		if (!rst_i) chk({7'h0, update_o}, {7'h0, upd_d});
		if (pend) begin
			exp_v = q.pop_front();
			chk(rdata_o, exp_v);
		end
		pend <= rd_i && ce_i && !rst_i;
		if (rst_i) begin
			upd_d <= 0;
		end else if (ce_i) begin
			upd_d <= wr_i && addr_i == UPDATE_ADDR && wdata_i == UPDATE_CODE;
		end
	end
	initial begin
		#20000;
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 0;
		acc(16'h0d40, 8'h00, 0);
		for (it = 0; it < 16; it++) begin
			acc(UPDATE_ADDR, UPDATE_CODE, 1);
			if (it[0]) frz();
			acc(16'h0d40, 8'h00, 0);
			acc(16'h0d40, 8'hff, 1);
			acc(UPDATE_ADDR, 8'h02, 1);
			acc(16'h0d28, 8'hff, 1);
			foreach (al[i]) acc(al[i], 8'h00, 0);
		end
		idle();
		@(posedge ref_clk_i);
		rst_i <= 1;
		sv = '0;
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 0;
		foreach (al[i]) acc(al[i], 8'h00, 0);
		idle();
		repeat (3) @(posedge ref_clk_i);
		end_of_test();
	end
endmodule : tb_top
